//--- rtl/psc_config_words.v
`timescale 1ns/1ps
`include "psc_map.vh"

module psc_config_words
(
  input  wire        clk_sys,           // system clock, 100 MHz
  input  wire        rst,               // synchronous reset, active high
  input  wire        serialClock,       // serial load clock pin
  input  wire        serialData,        // serial data pin
  input  wire        serialLoadEnable,  // load enable pin, low while shifting
  input  wire [9:0]  refDividerCode,    // reference divider code
  input  wire [2:0]  refDelayCode,      // reference delay code
  input  wire [2:0]  pulseWidthCode,    // detector pulse width code
  input  wire [3:0]  pumpCurrentCode,   // charge pump current code
  input  wire [2:0]  feedbackSelCode,   // feedback source select code
  input  wire        compareStrobe,     // one pulse per detector comparison
  input  wire        compareInWindow,   // edges inside lock window
  input  wire        refCycleMissing,   // pulse: a reference cycle missed
  input  wire        refCyclePresent,   // pulse: a reference cycle seen
  output reg  [10:0] fbDivRatio,        // feedback division ratio
  output reg  [10:0] refDivRatio,       // reference division ratio
  output reg  [11:0] fbDelayPs,         // feedback delay, ps
  output reg  [11:0] refDelayPs,        // reference delay, ps
  output reg  [24:0] outDivRatio,       // five 5-bit output ratios
  output reg  [4:0]  outEnable,         // output drivers on
  output reg         pumpPolarity,      // charge pump polarity
  output reg         extResistorSel,    // external resistor in use
  output reg         holdoverEnable,    // holdover function enabled
  output reg         holdoverActive,    // device in frequency holdover
  output reg         powerDown,         // soft power-down active
  output reg         dividerHoldReset,  // dividers held in reset
  output reg         bandgapEnable,     // bandgap reference on
  output reg  [11:0] lockWindowPs,      // lock window half-width, ps
  output reg         lockStatus,        // loop locked
  output reg  [11:0] pulseWidthPs,      // extra detector pulse width, ps
  output reg  [13:0] pumpCurrentUa,     // pump current, microamps
  output reg  [2:0]  feedbackOutput     // output index fed back
);

  // pin synchronisers; first stage read only by second
  reg  [2:0]  pinMeta_reg;
  reg  [2:0]  pinSync_reg;
  reg  [2:0]  pinPrev_reg;
  // serial shift stage and the stored words
  reg  [31:0] shift_reg;
  reg  [31:0] word1_reg;
  reg  [31:0] word2_reg;
  reg  [31:0] word3_reg;
  // lock run length, saturating at five
  reg  [2:0]  lockCount_reg;
  reg  [2:0]  lockCount_next;
  // edge strobes and the word on its way in
  wire        clkRise;
  wire        loadRise;
  wire [31:0] loadWord;
  wire [1:0]  loadSel;
  wire [24:0] outRatioNext;

  // three pins sampled together; pins idle high, so reset
  // to ones keeps a false edge from following reset
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      pinMeta_reg <= 3'h7;
      pinSync_reg <= 3'h7;
      pinPrev_reg <= 3'h7;
    end
    else
    begin
      pinMeta_reg <= {serialLoadEnable, serialData, serialClock};
      pinSync_reg <= pinMeta_reg;
      pinPrev_reg <= pinSync_reg;
    end
  end

  // edges found on the synchronised copies only
  assign clkRise  = pinSync_reg[0] & ~pinPrev_reg[0];
  assign loadRise = pinSync_reg[2] & ~pinPrev_reg[2];
  assign loadWord = shift_reg;
  assign loadSel  = shift_reg[`PSC_SEL_LSB+1:`PSC_SEL_LSB];

  // a cut frame keeps older bits; only the last 32 count
  // shift msb first while enable low
  always @(posedge clk_sys)
  begin
    if (rst)
      shift_reg <= 32'h0000_0000;
    else if (clkRise && !pinSync_reg[2])
      shift_reg <= {shift_reg[30:0], pinSync_reg[1]};
  end

  // transfer on load-enable rise by select
  // word 1 holds until reload or power-down, words 2 and 3 until reload
  // select codes 01, 10, 11; no readback path exists
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      word1_reg <= `PSC_W1_RESET;
      word2_reg <= `PSC_W2_RESET;
      word3_reg <= `PSC_W3_RESET;
    end
    else
    begin
      if (loadRise && loadSel == `PSC_SEL_W2)
        word2_reg <= loadWord;
      if (loadRise && loadSel == `PSC_SEL_W3)
        word3_reg <= loadWord;
      // power-down beats a word 1 load in the same cycle
      // power-down returns dividers to defaults
      if (!word2_reg[`PSC_PWRDN_N_BIT])
        word1_reg <= `PSC_W1_RESET;
      else if (loadRise && loadSel == `PSC_SEL_W1)
        word1_reg <= loadWord;
    end
  end

  // codes 5 to 7 all fall through to divide by 8
  // per-output divider select decode
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : gOutSel
      wire [2:0] sel;
      assign sel = word1_reg[`PSC_OUTSEL_LSB+gi*3+2:`PSC_OUTSEL_LSB+gi*3];
      assign outRatioNext[gi*5+4:gi*5] = (sel == 3'h0) ? 5'h01 :
                                         (sel == 3'h1) ? 5'h02 :
                                         (sel == 3'h2) ? 5'h04 :
                                         (sel == 3'h4) ? 5'h10 : 5'h08;
    end
  endgenerate

  // typical figures only; real delay moves with supply
  // delay code to typical picoseconds
  function [11:0] delayPs;
    input [2:0] code;
    begin
      case (code)
        3'h0:    delayPs = 12'h000;
        3'h1:    delayPs = 12'h096;
        3'h2:    delayPs = 12'h12C;
        3'h3:    delayPs = 12'h1C2;
        3'h4:    delayPs = 12'h258;
        3'h5:    delayPs = 12'h2EE;
        3'h6:    delayPs = 12'h5DC;
        default: delayPs = 12'hABE;
      endcase
    end
  endfunction

  // saturates so the flag holds while strobes keep hitting
  // count successive in-window comparisons
  always @*
  begin
    lockCount_next = lockCount_reg;
    if (!word2_reg[`PSC_PWRDN_N_BIT] || !word2_reg[`PSC_DIVRST_N_BIT])
      lockCount_next = 3'h0;
    else if (compareStrobe && !compareInWindow)
      lockCount_next = 3'h0;
    else if (compareStrobe && lockCount_reg != `PSC_LOCK_PERIODS)
      lockCount_next = lockCount_reg + 3'h1;
  end

  // flag registered so the lock pin comes from a flop
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      lockCount_reg <= 3'h0;
      lockStatus    <= 1'b0;
    end
    else
    begin
      lockCount_reg <= lockCount_next;
      lockStatus    <= (lockCount_next == `PSC_LOCK_PERIODS);
    end
  end

  // a miss beats a present pulse in the same cycle
  // holdover on first missing reference cycle
  always @(posedge clk_sys)
  begin
    if (rst)
      holdoverActive <= 1'b0;
    else if (!word2_reg[`PSC_HOLD_BIT] || !word2_reg[`PSC_PWRDN_N_BIT])
      holdoverActive <= 1'b0;
    else if (refCycleMissing)
      holdoverActive <= 1'b1;
    else if (refCyclePresent)
      holdoverActive <= 1'b0;
  end

  // decoded fields, registered so every output is a flop
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      // reset shows the power-up decode, except outDivRatio and outEnable held at zero
      fbDivRatio       <= 11'h080;
      refDivRatio      <= 11'h080;
      fbDelayPs        <= 12'h000;
      refDelayPs       <= 12'h000;
      outDivRatio      <= 25'h0000_000;
      outEnable        <= 5'h00;
      pumpPolarity     <= 1'b1;
      extResistorSel   <= 1'b0;
      holdoverEnable   <= 1'b0;
      powerDown        <= 1'b0;
      dividerHoldReset <= 1'b0;
      bandgapEnable    <= 1'b1;
      lockWindowPs     <= 12'h4B0;
      pulseWidthPs     <= 12'h000;
      pumpCurrentUa    <= 14'h07D0;
      feedbackOutput   <= 3'h3;
    end
    else
    begin
      fbDivRatio <= {1'b0, word1_reg[`PSC_FBDIV_MSB:`PSC_FBDIV_LSB]} + 11'h001;
      // word 0 codes arrive as ports, not through the store
      // same encoding; default forced by power-down
      if (!word2_reg[`PSC_PWRDN_N_BIT])
        refDivRatio <= 11'h080;
      else
        refDivRatio <= {1'b0, refDividerCode} + 11'h001;
      // both delay fields share the table
      fbDelayPs  <= delayPs(word1_reg[`PSC_FBDLY_MSB:`PSC_FBDLY_LSB]);
      refDelayPs <= delayPs(refDelayCode);
      outDivRatio <= outRatioNext;
      // outputs released only when powered up
      outEnable <= word2_reg[`PSC_PWRDN_N_BIT] ? 5'h1F : 5'h00;
      pumpPolarity <= word1_reg[`PSC_POLARITY_BIT];
      extResistorSel <= word1_reg[`PSC_EXTRES_BIT];
      holdoverEnable <= word2_reg[`PSC_HOLD_BIT];
      powerDown <= ~word2_reg[`PSC_PWRDN_N_BIT];
      dividerHoldReset <= ~word2_reg[`PSC_DIVRST_N_BIT];
      bandgapEnable <= word2_reg[`PSC_BANDGAP_BIT];
      // window value only; the phase compare lives outside
      // lock window half-width
      case (word2_reg[`PSC_LOCK_WINDOW_SELECT_MSB:`PSC_LOCK_WINDOW_SELECT_LSB])
        2'h0:    lockWindowPs <= 12'h4B0;
        2'h1:    lockWindowPs <= 12'h708;
        2'h2:    lockWindowPs <= 12'h960;
        default: lockWindowPs <= 12'hBB8;
      endcase
      // extra pulse width; code 7 has no entry, taken as none
      case (pulseWidthCode)
        3'h1:    pulseWidthPs <= 12'h12C;
        3'h2:    pulseWidthPs <= 12'h258;
        3'h3:    pulseWidthPs <= 12'h384;
        3'h4:    pulseWidthPs <= 12'h834;
        3'h5:    pulseWidthPs <= 12'hA8C;
        3'h6:    pulseWidthPs <= 12'hE74;
        default: pulseWidthPs <= 12'h000;
      endcase
      // codes are widened first so the product cannot wrap
      // 625 uA steps or 1 mA steps
      if (pumpCurrentCode[3])
        pumpCurrentUa <= ({11'h000, pumpCurrentCode[2:0]} + 14'h0001) * 14'h03E8;
      else
        pumpCurrentUa <= ({10'h000, pumpCurrentCode} + 14'h0001) * 14'h0271;
      // every spare code feeds output 3 back
      // feedback source routing
      case (feedbackSelCode)
        3'h0:    feedbackOutput <= 3'h0;
        3'h1:    feedbackOutput <= 3'h1;
        3'h2:    feedbackOutput <= 3'h2;
        3'h3:    feedbackOutput <= 3'h4;
        default: feedbackOutput <= 3'h3;
      endcase
    end
  end

endmodule

//--- rtl/psc_map.vh
`ifndef PSC_MAP_VH
`define PSC_MAP_VH
// word select codes in bits 1:0
`define PSC_SEL_LSB       0
`define PSC_SEL_W1        2'h1
`define PSC_SEL_W2        2'h2
`define PSC_SEL_W3        2'h3
`define PSC_WORD_BITS     32
// feedback_and_output_select_word fields
`define PSC_FBDIV_LSB     2
`define PSC_FBDIV_MSB     11
`define PSC_FBDLY_LSB     12
`define PSC_FBDLY_MSB     14
`define PSC_OUTSEL_LSB    15
`define PSC_OUTSEL_W      3
`define PSC_POLARITY_BIT  30
`define PSC_EXTRES_BIT    31
`define PSC_W1_RESET      32'h5B44_01FD
// loop_control_word fields
`define PSC_HOLD_BIT      2
`define PSC_PWRDN_N_BIT   3
`define PSC_DIVRST_N_BIT  4
`define PSC_BANDGAP_BIT   5
`define PSC_LOCK_WINDOW_SELECT_LSB     6
`define PSC_LOCK_WINDOW_SELECT_MSB     7
`define PSC_W2_RESET      32'h0000_003A
// reserved_zero_word
`define PSC_W3_RESET      32'h0000_0003
// lock detect: successive in-window periods
`define PSC_LOCK_PERIODS  3'h5
`endif

//--- verification/pll_sync_config_words_tb.sv
`timescale 1ns/1ps
module pll_sync_config_words_tb;
  reg         clk_sys = 1'b0, rst = 1'b1;
  reg  [9:0]  refDividerCode = 10'h07F;
  reg  [3:0]  pumpCurrentCode = 4'h9;
  reg  [2:0]  refDelayCode = 3'h0, pulseWidthCode = 3'h0, feedbackSelCode = 3'h4;
  reg         compareStrobe = 1'b0, compareInWindow = 1'b0;
  reg         refCycleMissing = 1'b0, refCyclePresent = 1'b0;
  wire        serialClock, serialData, serialLoadEnable, pumpPolarity, extResistorSel;
  wire        holdoverEnable, holdoverActive, powerDown, dividerHoldReset, bandgapEnable;
  wire        lockStatus;
  wire [10:0] fbDivRatio, refDivRatio;
  wire [11:0] fbDelayPs, refDelayPs, lockWindowPs, pulseWidthPs;
  wire [24:0] outDivRatio;
  wire [4:0]  outEnable;
  wire [13:0] pumpCurrentUa;
  wire [2:0]  feedbackOutput;
  integer     n_fail = 0, total_checks = 0, i;
  reg  [31:0] w;
  psc_config_words uut (.*);
  psc_host_model host (.*);
  initial forever #5 clk_sys = ~clk_sys;
  // expected decodes
  function [11:0] dly(input [2:0] c);
    dly = (c < 3'h6) ? 12'h096 * c : (c == 3'h6) ? 12'h5DC : 12'hABE;
  endfunction
  function [4:0] odiv(input [2:0] c);
    odiv = (c > 3'h4) ? 5'h08 : 5'h01 << c;
  endfunction
  function [11:0] pw(input [2:0] c);
    pw = (c < 3'h4) ? 12'h12C * c : (c == 3'h4) ? 12'h834 : (c == 3'h5) ? 12'hA8C
       : (c == 3'h6) ? 12'hE74 : 12'h000;
  endfunction
  function [2:0] fbo(input [2:0] c);
    fbo = (c < 3'h3) ? c : (c == 3'h3) ? 3'h4 : 3'h3;
  endfunction
  function [13:0] pmp(input [3:0] c);
    pmp = c[3] ? 14'h03E8 * (c[2:0] + 3'h1) : 14'h0271 * (c + 4'h1);
  endfunction
  task check(input string nm, input [63:0] seen, input [63:0] exp);
  begin
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task ld(input [31:0] v);
  begin
    @(negedge clk_sys);
    host.send(v);
  end
  endtask
  // one comparison pulse, window flag flipped after it
  task cmp(input win);
  begin
    @(negedge clk_sys);
    {compareStrobe, compareInWindow} = {1'b1, win};
    @(negedge clk_sys);
    {compareStrobe, compareInWindow} = {1'b0, ~win};
    repeat (2) @(negedge clk_sys);
  end
  endtask
  task close_out;
  begin
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // hang guard, far past the eighteen words of traffic
  initial
  begin
    #200_000;
    n_fail = n_fail + 1;
    close_out;
  end
  initial
  begin
    w = $urandom(13806);
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    check("dflt1", {fbDivRatio, outDivRatio, fbDelayPs, extResistorSel, pumpPolarity},
      {11'h080, 25'h84_1041, 12'h000, 2'h1});
    check("dflt2", {outEnable, holdoverEnable, powerDown, dividerHoldReset, bandgapEnable,
      lockWindowPs, refDivRatio}, {5'h1F, 4'h1, 12'h4B0, 11'h080});
    // every delay and select code, ratio extremes first and last
    for (i = 0; i < 8; i = i + 1)
    begin
      w = $urandom;
      w[29:0] = {i[2:0] + 3'h4, i[2:0] + 3'h3, i[2:0] + 3'h2, i[2:0] + 3'h1, i[2:0], i[2:0],
        (i == 0) ? 10'h000 : (i == 7) ? 10'h3FF : w[11:2], 2'h1};
      ld(w);
      check("fbdiv", fbDivRatio, w[11:2] + 11'h001);
      check("fbdly", fbDelayPs, dly(w[14:12]));
      check("odiv", outDivRatio, {odiv(w[29:27]), odiv(w[26:24]), odiv(w[23:21]),
        odiv(w[20:18]), odiv(w[17:15])});
      check("pol", {extResistorSel, pumpPolarity}, w[31:30]);
    end
    // random reserved bits must change nothing
    for (i = 0; i < 4; i = i + 1)
    begin
      w = $urandom;
      w[7:0] = {i[1:0], w[5:4], 1'b1, w[2], 2'h2};
      ld(w);
      check("w2", {holdoverEnable, dividerHoldReset, bandgapEnable, powerDown},
        {w[2], ~w[4], w[5], 1'b0});
      check("lock_window_select", lockWindowPs, 12'h4B0 + 12'h258 * i[1:0]);
    end
    $display("test words done");
    for (i = 0; i < 16; i = i + 1)
    begin
      w = $urandom;
      @(negedge clk_sys);
      {pumpCurrentCode, refDelayCode, pulseWidthCode} = {i[3:0], ~i[2:0], i[2:0]};
      // every route is tried, rate is not judged
      feedbackSelCode = i[2:0];
      refDividerCode = (i < 2) ? 10'h3FF - {i[0], 1'b0} : w[12:3];
      repeat (3) @(negedge clk_sys);
      check("refdiv", refDivRatio, refDividerCode + 11'h001);
      check("refdly", refDelayPs, dly(refDelayCode));
      check("pw", pulseWidthPs, pw(pulseWidthCode));
      check("fbsel", feedbackOutput, fbo(feedbackSelCode));
      check("pump", pumpCurrentUa, pmp(pumpCurrentCode));
    end
    ld(32'h0000_003E);
    // a miss after four hits restarts the count
    for (i = 0; i < 10; i = i + 1)
    begin
      cmp(i != 4);
      if (i == 3 || i > 7)
        check("lock", lockStatus, i == 9);
    end
    cmp(1'b0);
    check("unlock", lockStatus, 1'b0);
    for (i = 0; i < 2; i = i + 1)
    begin
      @(negedge clk_sys);
      {refCycleMissing, refCyclePresent} = {~i[0], i[0]};
      @(negedge clk_sys);
      {refCycleMissing, refCyclePresent} = 2'h0;
      check("hold", holdoverActive, {~i[0]});
    end
    $display("test lock done");
    w = $urandom;
    ld({w[31:2], 2'h0});
    ld(32'h0000_0003);
    check("keep", {fbDivRatio, holdoverEnable}, {11'h400, 1'b1});
    ld(32'h0000_0032);
    check("pd", {powerDown, outEnable, fbDivRatio, refDivRatio},
      {1'b1, 5'h00, 11'h080, 11'h080});
    ld(32'h5FFF_FFFD);
    ld(32'h0000_003A);
    check("up", {powerDown, outEnable, fbDivRatio}, {1'b0, 5'h1F, 11'h080});
    $display("test power done");
    close_out;
  end
endmodule

//--- verification/psc_config_words_properties.sv
`timescale 1ns/1ps
module psc_config_checker
(
  input wire        clk_sys,          // clock
  input wire        rst,              // reset
  input wire [9:0]  refDividerCode,   // ref code
  input wire [3:0]  pumpCurrentCode,  // pump code
  input wire        compareStrobe,    // compare
  input wire        compareInWindow,  // in window
  input wire        refCycleMissing,  // ref missed
  input wire        refCyclePresent,  // ref seen
  input wire [10:0] refDivRatio,      // ref ratio
  input wire [4:0]  outEnable,        // drivers
  input wire        holdoverEnable,   // hold on
  input wire        holdoverActive,   // holding
  input wire        powerDown,        // powered down
  input wire        lockStatus,       // locked
  input wire [13:0] pumpCurrentUa     // pump current
);
  wire hit = compareStrobe && compareInWindow;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // outputs lag one edge, so $past(rst) guards the first edge after reset
  property p_lock_drop;
    compareStrobe && !compareInWindow |-> ##[1:2] !lockStatus;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("lock kept");
  property p_lock_rise;
    $rose(lockStatus) |-> $past(hit) || $past(hit, 2);
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock rose");
  property p_hold_in;
    holdoverEnable && !powerDown && refCycleMissing && !refCyclePresent
      |-> ##[1:2] holdoverActive;
  endproperty
  a_hold_in: assert property (p_hold_in) else $error("no hold");
  property p_hold_out;
    refCyclePresent && !refCycleMissing |-> ##[1:2] !holdoverActive;
  endproperty
  a_hold_out: assert property (p_hold_out) else $error("hold kept");
  property p_pd_off;
    powerDown && $past(powerDown) |-> outEnable == 5'h00 && refDivRatio == 11'h080;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("pd outputs");
  property p_run_on;
    !powerDown && !$past(powerDown) && !$past(rst) |-> outEnable == 5'h1F;
  endproperty
  a_run_on: assert property (p_run_on) else $error("outputs off");
  property p_ref_div;
    !$past(rst) && !powerDown && $stable(powerDown) && $stable(refDividerCode)
      |-> refDivRatio == refDividerCode + 11'h001;
  endproperty
  a_ref_div: assert property (p_ref_div) else $error("ref ratio");
  property p_pump;
    !$past(rst) && $stable(pumpCurrentCode) |-> pumpCurrentUa == (pumpCurrentCode[3]
      ? 14'h03E8 * (pumpCurrentCode[2:0] + 14'h0001) : 14'h0271 * (pumpCurrentCode + 14'h0001));
  endproperty
  a_pump: assert property (p_pump) else $error("pump current");
  c_lock: cover property ($rose(lockStatus));
  c_hold: cover property ($rose(holdoverActive));
  c_pd: cover property ($rose(powerDown));
endmodule
bind psc_config_words psc_config_checker chk (.clk_sys, .rst, .refDividerCode, .pumpCurrentCode,
  .compareStrobe, .compareInWindow, .refCycleMissing, .refCyclePresent, .refDivRatio,
  .outEnable, .holdoverEnable, .holdoverActive, .powerDown, .lockStatus, .pumpCurrentUa);

//--- verification/psc_host_model.sv
`timescale 1ns/1ps
module psc_host_model
(
  output reg serialClock,      // link clock
  output reg serialData,       // link data
  output reg serialLoadEnable  // low while shifting
);
  // idle at pull-up level, clock still between words
  initial
  begin
    {serialClock, serialData, serialLoadEnable} = 3'h7;
  end
  task send(input [31:0] w);
    integer i;
    begin
      serialLoadEnable = 1'b0;
      // quarter step keeps link edges clear of clk_sys rises
      #1.25;
      for (i = 31; i >= 0; i = i - 1)
      begin
        #62.5 {serialClock, serialData} = {1'b0, w[i]};
        #62.5 serialClock = 1'b1;
      end
      #62.5 {serialData, serialLoadEnable} = 2'h3;
      #250;
    end
  endtask
endmodule
